// ==== rtl/isra_dev.sv ====
`timescale 1ns/1ns
`default_nettype none
module isra_dev #(
  parameter logic [6:0] OWN_ADDR = isra_pkg::DEV_ADDR_DFLT
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  isra_if.dev BUS,
  output logic WR_STB,
  output logic [7:0] WR_ADDR,
  output logic [7:0] WR_DATA,
  output logic RD_STB,
  output logic [7:0] RD_ADDR,
  input wire logic [7:0] RD_DATA
);
  import isra_pkg::*;

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    isra_dst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] reg_addr;
    logic have_reg;
    logic txm;
    logic mack;
    logic oe_n;
    logic req_tgl;
    logic req_wr;
    logic [7:0] req_addr;
    logic [7:0] req_data;
    logic ack1;
    logic ack2;
    logic ack3;
    logic [7:0] rdata;
  } isra_lnk_t;

  typedef struct packed {
    logic r1;
    logic r2;
    logic r3;
    logic pend_rd;
    logic ack_tgl;
    logic [7:0] rdata;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_stb;
    logic [7:0] rd_addr;
  } isra_usr_t;

  isra_lnk_t l_q;
  isra_lnk_t l_d;
  isra_usr_t c_q;
  isra_usr_t c_d;
  logic [1:0] lrst_q;

  // Hand one register access to the user domain; fields stay put until the next toggle
  function automatic isra_lnk_t issue(isra_lnk_t s, logic wr, logic [7:0] a, logic [7:0] d);
    s.req_tgl = ~s.req_tgl;
    s.req_wr = wr;
    s.req_addr = a;
    s.req_data = d;
    return s;
  endfunction

  // First transmit bit goes out at once; the rest follow on later falls
  function automatic isra_lnk_t tx_load(isra_lnk_t s);
    s.st = D_TX;
    s.oe_n = s.rdata[7];
    s.sh = {s.rdata[6:0], 1'b0};
    s.cnt = 4'h1;
    return s;
  endfunction

  // Reset is carried into the link domain by its own pair of flops
  always_ff @(posedge LINK_CLK) begin
    lrst_q <= {lrst_q[0], RST};
  end

  always_comb begin
    logic rise;
    logic fall;
    logic high;
    logic start;
    logic stop;
    rise = 1'b0;
    fall = 1'b0;
    high = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    l_d = l_q;
    l_d.scl1 = BUS.scl;
    l_d.scl2 = l_q.scl1;
    l_d.scl3 = l_q.scl2;
    l_d.sda1 = BUS.sda;
    l_d.sda2 = l_q.sda1;
    l_d.sda3 = l_q.sda2;
    l_d.ack1 = c_q.ack_tgl;
    l_d.ack2 = l_q.ack1;
    l_d.ack3 = l_q.ack2;
    if (l_q.ack2 != l_q.ack3) begin
      l_d.rdata = c_q.rdata;
    end
    rise = l_q.scl2 & ~l_q.scl3;
    fall = ~l_q.scl2 & l_q.scl3;
    high = l_q.scl2 & l_q.scl3;
    start = high & l_q.sda3 & ~l_q.sda2;
    stop = high & ~l_q.sda3 & l_q.sda2;
    if (start) begin
      // Any start, repeated or not, drops what was going on
      l_d.st = D_ADDR;
      l_d.cnt = 4'h0;
      l_d.have_reg = 1'b0;
      l_d.oe_n = 1'b1;
    end else if (stop) begin
      l_d.st = D_IDLE;
      l_d.oe_n = 1'b1;
    end else begin
      unique case (l_q.st)
        D_IDLE: begin
          l_d.oe_n = 1'b1;
        end
        D_ADDR, D_RX: begin
          if (rise && l_q.cnt < BYTE_BITS) begin
            l_d.sh = {l_q.sh[6:0], l_q.sda2};
            l_d.cnt = l_q.cnt + 4'h1;
          end else if (fall && l_q.cnt == BYTE_BITS) begin
            if (l_q.st == D_ADDR) begin
              if (l_q.sh[7:1] == OWN_ADDR) begin
                l_d.oe_n = 1'b0;
                l_d.st = D_ACK;
                l_d.txm = l_q.sh[0];
                if (l_q.sh[0]) begin
                  // Fetch now so the byte is ready by the end of the ack slot
                  l_d = issue(l_d, 1'b0, l_q.reg_addr, l_q.sh);
                end
              end else begin
                l_d.st = D_IDLE;
              end
            end else begin
              l_d.oe_n = 1'b0;
              l_d.st = D_ACK;
              if (l_q.have_reg) begin
                l_d = issue(l_d, 1'b1, l_q.reg_addr, l_q.sh);
                l_d.reg_addr = l_q.reg_addr + 8'h01;
              end else begin
                l_d.reg_addr = l_q.sh;
                l_d.have_reg = 1'b1;
              end
            end
          end
        end
        D_ACK: begin
          if (fall) begin
            l_d.oe_n = 1'b1;
            l_d.cnt = 4'h0;
            if (l_q.txm) begin
              l_d = tx_load(l_d);
            end else begin
              l_d.st = D_RX;
            end
          end
        end
        D_TX: begin
          if (fall) begin
            if (l_q.cnt == BYTE_BITS) begin
              // Release for the master's acknowledge
              l_d.oe_n = 1'b1;
              l_d.st = D_MACK;
              l_d.mack = 1'b0;
            end else begin
              l_d.oe_n = l_q.sh[7];
              l_d.sh = {l_q.sh[6:0], 1'b0};
              l_d.cnt = l_q.cnt + 4'h1;
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            l_d.mack = ~l_q.sda2;
            if (!l_q.sda2) begin
              l_d.reg_addr = l_q.reg_addr + 8'h01;
              l_d = issue(l_d, 1'b0, l_q.reg_addr + 8'h01, l_q.sh);
            end
          end else if (fall) begin
            if (l_q.mack) begin
              l_d = tx_load(l_d);
            end else begin
              l_d.st = D_IDLE;
            end
          end
        end
        default: begin
          l_d.st = D_IDLE;
          l_d.oe_n = 1'b1;
        end
      endcase
    end
    if (lrst_q[1]) begin
      l_d = '0;
      l_d.scl1 = 1'b1;
      l_d.scl2 = 1'b1;
      l_d.scl3 = 1'b1;
      l_d.sda1 = 1'b1;
      l_d.sda2 = 1'b1;
      l_d.sda3 = 1'b1;
      l_d.st = D_IDLE;
      l_d.oe_n = 1'b1;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    l_q <= l_d;
  end

  // User side: request fields are stable once the toggle has crossed
  always_comb begin
    c_d = c_q;
    c_d.wr_stb = 1'b0;
    c_d.rd_stb = 1'b0;
    c_d.r1 = l_q.req_tgl;
    c_d.r2 = c_q.r1;
    c_d.r3 = c_q.r2;
    if (c_q.pend_rd) begin
      c_d.rdata = RD_DATA;
      c_d.ack_tgl = ~c_q.ack_tgl;
      c_d.pend_rd = 1'b0;
    end
    if (c_q.r2 != c_q.r3) begin
      if (l_q.req_wr) begin
        c_d.wr_stb = 1'b1;
        c_d.wr_addr = l_q.req_addr;
        c_d.wr_data = l_q.req_data;
      end else begin
        c_d.rd_stb = 1'b1;
        c_d.rd_addr = l_q.req_addr;
        c_d.pend_rd = 1'b1;
      end
    end
    if (RST) begin
      c_d = '0;
    end
  end

  always_ff @(posedge CLK) begin
    c_q <= c_d;
  end

  assign BUS.sda_s_o = 1'b0;
  assign BUS.sda_s_oe_n = l_q.oe_n;
  assign WR_STB = c_q.wr_stb;
  assign WR_ADDR = c_q.wr_addr;
  assign WR_DATA = c_q.wr_data;
  assign RD_STB = c_q.rd_stb;
  assign RD_ADDR = c_q.rd_addr;
endmodule
`default_nettype wire

// ==== pkg/isra_pkg.sv ====
`default_nettype none
package isra_pkg;
  // Host clock and the bit rate it derives for the serial clock
  localparam int CLK_HZ = 100_000_000;
  localparam int SCL_HZ = 200_000;
  // Each serial bit is four quarter steps of the host clock
  localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam int QTR_W = 8;
  // Own address default; the value is arbitrary
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] REL_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_ADDR = 3'h1,
    D_ACK = 3'h3,
    D_RX = 3'h2,
    D_TX = 3'h6,
    D_MACK = 3'h7
  } isra_dst_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h3,
    H_STOP = 2'h2
  } isra_hst_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h3,
    OP_STOP = 2'h2
  } isra_op_t;
endpackage
`default_nettype wire

// ==== pkg/isra_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface isra_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic sda;

  // Open-drain data line with pull-up: low whenever either end drives low
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

  modport host (
    output scl,
    output sda_m_o,
    output sda_m_oe_n,
    input sda
  );

  modport dev (
    input scl,
    input sda,
    output sda_s_o,
    output sda_s_oe_n
  );
endinterface
`default_nettype wire

// ==== rtl/isra_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module isra_host (
  input wire logic CLK,
  input wire logic RST,
  isra_if.host BUS,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire isra_pkg::isra_op_t CMD_OP,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_NACK,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_NACK
);
  import isra_pkg::*;

  typedef struct packed {
    logic sda1;
    logic sda2;
    isra_hst_t st;
    logic [1:0] ph;
    logic [QTR_W-1:0] qcnt;
    logic [3:0] bcnt;
    logic [8:0] tx;
    logic [8:0] rx;
    logic scl;
    logic oe_n;
    logic rdy;
    logic rsp_v;
    logic [7:0] rsp_data;
    logic rsp_nack;
  } isra_hs_t;

  isra_hs_t h_q;
  isra_hs_t h_d;

  always_comb begin
    logic tick;
    tick = h_q.qcnt == QTR_W'(QTR_CYC - 1);
    h_d = h_q;
    h_d.rsp_v = 1'b0;
    h_d.sda1 = BUS.sda;
    h_d.sda2 = h_q.sda1;
    h_d.qcnt = tick ? '0 : h_q.qcnt + QTR_W'(1);
    unique case (h_q.st)
      H_IDLE: begin
        if (CMD_VALID && h_q.rdy) begin
          h_d.rdy = 1'b0;
          h_d.ph = 2'h0;
          h_d.bcnt = 4'h0;
          unique case (CMD_OP)
            OP_START: h_d.st = H_START;
            OP_STOP: h_d.st = H_STOP;
            OP_WRITE: begin
              // Ninth bit released so the receiver can acknowledge
              h_d.tx = {CMD_DATA, 1'b1};
              h_d.st = H_BIT;
            end
            OP_READ: begin
              h_d.tx = {REL_BYTE, CMD_NACK};
              h_d.st = H_BIT;
            end
          endcase
        end
      end
      H_START: begin
        // Also serves as repeated start: data rises while the clock is low
        if (tick) begin
          h_d.ph = h_q.ph + 2'h1;
          unique case (h_q.ph)
            2'h0: h_d.oe_n = 1'b1;
            2'h1: h_d.scl = 1'b1;
            2'h2: h_d.oe_n = 1'b0;
            2'h3: begin
              h_d.scl = 1'b0;
              h_d.st = H_IDLE;
              h_d.rdy = 1'b1;
            end
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          h_d.ph = h_q.ph + 2'h1;
          unique case (h_q.ph)
            2'h0: h_d.oe_n = h_q.tx[8];
            2'h1: h_d.scl = 1'b1;
            2'h2: h_d.rx = {h_q.rx[7:0], h_q.sda2};
            2'h3: begin
              h_d.scl = 1'b0;
              h_d.tx = {h_q.tx[7:0], 1'b1};
              h_d.bcnt = h_q.bcnt + 4'h1;
              if (h_q.bcnt == BYTE_BITS) begin
                // Data line is left as is; the next command sets it while the clock is low
                h_d.st = H_IDLE;
                h_d.rdy = 1'b1;
                h_d.rsp_v = 1'b1;
                h_d.rsp_data = h_q.rx[8:1];
                h_d.rsp_nack = h_q.rx[0];
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          h_d.ph = h_q.ph + 2'h1;
          unique case (h_q.ph)
            2'h0: h_d.oe_n = 1'b0;
            2'h1: h_d.scl = 1'b1;
            2'h2: h_d.oe_n = 1'b1;
            2'h3: begin
              h_d.st = H_IDLE;
              h_d.rdy = 1'b1;
            end
          endcase
        end
      end
    endcase
    if (RST) begin
      h_d = '0;
      h_d.sda1 = 1'b1;
      h_d.sda2 = 1'b1;
      h_d.st = H_IDLE;
      // Idle and ready straight out of reset, or no first command is ever taken
      h_d.rdy = 1'b1;
      h_d.scl = 1'b1;
      h_d.oe_n = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    h_q <= h_d;
  end

  assign BUS.scl = h_q.scl;
  assign BUS.sda_m_o = 1'b0;
  assign BUS.sda_m_oe_n = h_q.oe_n;
  assign CMD_READY = h_q.rdy;
  assign RSP_VALID = h_q.rsp_v;
  assign RSP_DATA = h_q.rsp_data;
  assign RSP_NACK = h_q.rsp_nack;
endmodule
`default_nettype wire

// ==== sim/isra_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module isra_props #(
  parameter logic [6:0] OWN_ADDR = isra_pkg::DEV_ADDR_DFLT
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n
);
  typedef struct packed {
    logic scl;
    logic sda;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first;
  } isra_mon_t;
  isra_mon_t mon_q;
  isra_mon_t mon_d;
  logic [3:0] quiet_q;

  // The link side is reset a few of its own clocks after the host, so checks wait for it
  always_ff @(posedge CLK) begin
    if (RST) begin
      quiet_q <= 4'hF;
    end else if (quiet_q != 4'h0) begin
      quiet_q <= quiet_q - 4'h1;
    end
  end

  // Bit tracker restarts on any start so a repeated start frames a new address byte
  always_comb begin
    mon_d = mon_q;
    mon_d.scl = scl;
    mon_d.sda = sda;
    if (scl && mon_q.scl && mon_q.sda && !sda) begin
      mon_d.cnt = 4'h0;
      mon_d.first = 1'b1;
    end else if (scl && !mon_q.scl) begin
      if (mon_q.cnt == 4'h8) begin
        mon_d.cnt = 4'h0;
        mon_d.first = 1'b0;
      end else begin
        mon_d.cnt = mon_q.cnt + 4'h1;
        mon_d.sh = {mon_q.sh[6:0], sda};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mon_q <= '0;
    end else begin
      mon_q <= mon_d;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST || quiet_q != 4'h0);

  sequence s_addr_ninth;
    mon_q.first && scl && !mon_q.scl && mon_q.cnt == 4'h8;
  endsequence

  AST_ADDR_ACK: assert property (s_addr_ninth ##0 mon_q.sh[7:1] == OWN_ADDR |-> !sda)
    else $error("own address not acknowledged");
  AST_ADDR_IGN: assert property (s_addr_ninth ##0 mon_q.sh[7:1] != OWN_ADDR |-> sda)
    else $error("foreign address acknowledged");
  AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(sda_s_oe_n))
    else $error("device data moved while clock high");
  AST_NO_CLASH: assert property (scl && !sda_s_oe_n |-> sda_m_oe_n)
    else $error("both ends drive data while clock high");
  AST_START_HOST: assert property (scl && $past(scl) && $fell(sda) |-> !sda_m_oe_n)
    else $error("start not made by host");
  AST_STOP_HOST: assert property (scl && $past(scl) && $rose(sda) |-> sda_s_oe_n)
    else $error("stop while device drives");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import isra_pkg::*;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid;
  logic cmd_ready;
  isra_op_t cmd_op;
  logic [7:0] cmd_data;
  logic cmd_nack;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic rd_stb;
  logic [7:0] rd_cnt = 8'h00;
  logic [7:0] mem [256];
  logic [7:0] rsp_d;
  logic [7:0] rsp_n;
  int errors = 0;
  int compares = 0;

  always #5 clk = ~clk;
  always #24 link_clk = ~link_clk;

  isra_if isra_if_inst();
  isra_host isra_host_inst (.CLK(clk), .RST(rst), .BUS(isra_if_inst.host),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_DATA(cmd_data),
    .CMD_NACK(cmd_nack), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_NACK(rsp_nack));
  isra_dev isra_dev_inst (.CLK(clk), .RST(rst), .LINK_CLK(link_clk), .BUS(isra_if_inst.dev),
    .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_STB(rd_stb),
    .RD_ADDR(rd_addr), .RD_DATA(mem[rd_addr]));
  isra_props isra_props_inst (.CLK(clk), .RST(rst), .scl(isra_if_inst.scl),
    .sda(isra_if_inst.sda), .sda_m_oe_n(isra_if_inst.sda_m_oe_n),
    .sda_s_oe_n(isra_if_inst.sda_s_oe_n));

  // Register file behind the device, written only through its strobe
  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_stb === 1'b1) begin
      rd_cnt <= rd_cnt + 8'h01;
    end
  end

  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One command: held until taken, then for bytes a bounded wait for the response
  task automatic go(input isra_op_t op, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    @(posedge clk);
    cmd_op <= op;
    cmd_data <= d;
    cmd_nack <= nk;
    cmd_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      errors++;
      test_done;
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk);
    if (op == OP_WRITE || op == OP_READ) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (rsp_valid !== 1'b1 && n < 20000);
      if (n >= 20000) begin
        errors++;
        test_done;
      end
      rsp_d = rsp_data;
      rsp_n = {7'h00, rsp_nack};
    end
  endtask

  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
    // Ten host cycles still give the link side two samples of reset
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    go(OP_START, 8'h00, 1'b0);
    go(OP_WRITE, 8'h54, 1'b0);
    chk("address ack", rsp_n, 8'h00);
    go(OP_WRITE, 8'h10, 1'b0);
    chk("register ack", rsp_n, 8'h00);
    go(OP_WRITE, 8'h12, 1'b0);
    chk("data ack", rsp_n, 8'h00);
    go(OP_WRITE, 8'h34, 1'b0);
    chk("second data ack", rsp_n, 8'h00);
    go(OP_STOP, 8'h00, 1'b0);
    chk("reg 10", mem[8'h10], 8'h12);
    chk("reg 11", mem[8'h11], 8'h34);
    go(OP_START, 8'h00, 1'b0);
    go(OP_WRITE, 8'h54, 1'b0);
    go(OP_WRITE, 8'h10, 1'b0);
    go(OP_START, 8'h00, 1'b0);
    go(OP_WRITE, 8'h55, 1'b0);
    chk("read address ack", rsp_n, 8'h00);
    go(OP_READ, 8'h00, 1'b0);
    chk("read first", rsp_d, 8'h12);
    go(OP_READ, 8'h00, 1'b1);
    chk("read next", rsp_d, 8'h34);
    chk("final nack", rsp_n, 8'h01);
    chk("read fetches", rd_cnt, 8'h02);
    go(OP_STOP, 8'h00, 1'b0);
    go(OP_START, 8'h00, 1'b0);
    go(OP_WRITE, 8'h56, 1'b0);
    chk("foreign address", rsp_n, 8'h01);
    go(OP_WRITE, 8'h20, 1'b0);
    go(OP_STOP, 8'h00, 1'b0);
    chk("foreign ignored", mem[8'h20], 8'h00);
    go(OP_START, 8'h00, 1'b0);
    go(OP_WRITE, 8'h54, 1'b0);
    go(OP_WRITE, 8'h20, 1'b0);
    go(OP_WRITE, 8'hC1, 1'b0);
    go(OP_STOP, 8'h00, 1'b0);
    chk("reg 20", mem[8'h20], 8'hC1);
    test_done;
  end
endmodule
`default_nettype wire
